// [common/adcatc_pkg.sv]
// constants for the acquisition and trigger control block
package adcatc_pkg;
   // ************************************
   // register offsets
   // ************************************
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_DIV = 8'h04;
   localparam logic [7:0] ADDR_TRIG = 8'h08;
   localparam logic [7:0] ADDR_ABOUT = 8'h0c;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam logic [7:0] ADDR_MEM_IDX = 8'h14;
   localparam logic [7:0] ADDR_MEM_DATA = 8'h18;
   localparam logic [7:0] ADDR_CMD = 8'h1c;

   // ************************************
   // field positions
   // ************************************
   // control: channel, gains, mode, clock and trigger source
   localparam int CTRL_CHAN = 0;
   localparam int CTRL_GAIN0 = 4;
   localparam int CTRL_GAIN1 = 8;
   localparam int CTRL_MODE = 12;
   localparam int CTRL_EXT_CLK = 16;
   localparam int CTRL_EXT_TRIG = 17;
   // trigger: level, analog select, polarity, level sensitivity
   localparam int TRIG_LEVEL = 0;
   localparam int TRIG_ANALOG = 16;
   localparam int TRIG_NEG = 17;
   localparam int TRIG_LEVEL_SENS = 18;
   // command: start, stop
   localparam int CMD_START = 0;
   localparam int CMD_STOP = 1;

   // ************************************
   // reset values
   // ************************************
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] TRIG_RESET = 32'h0000_0000;
   localparam logic [15:0] ABOUT_RESET = 16'h0001;
   localparam logic [2:0] DIV_CODE_RESET = 3'h0;

   // ************************************
   // divider and timing
   // ************************************
   localparam logic [15:0] DIV_MIN = 16'h0020;
   localparam logic [15:0] DIV_MAX = 16'h1000;
   localparam int TRIG_DELAY_NS = 100;
   localparam int CLK_PERIOD_NS = 20;
   localparam int TRIG_DELAY_CYC = (TRIG_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      MODE_POST,
      MODE_PRE,
      MODE_ABOUT
   } adcatc_mode_t;
endpackage

// [hw/adcatc_top.sv]
// acquisition, pacing and trigger control with apb register access
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/10ps
module adcatc_top #(
   parameter int SMP_W = 16,
   parameter int DEPTH = 1024
) (
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic i_ext_clk,
   input wire logic i_ext_trig,
   input wire logic i_smp_valid,
   input wire logic [SMP_W-1:0] i_smp_data,
   output logic o_chan,
   output logic [2:0] o_gain,
   output logic o_conv_run,
   output logic [2:0] o_div_code,
   output logic o_conv_strobe,
   output logic o_busy,
   output logic o_done
);
   localparam int AW = $clog2(DEPTH);
   localparam int DLY_W = $clog2(adcatc_pkg::TRIG_DELAY_CYC + 1);

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_WAIT_TRIG,
      ST_POST_RUN,
      ST_PRE_RUN,
      ST_POST_CNT
   } adcatc_state_t;

   // ************************************
   // reset release
   // ************************************
   logic rst_meta;
   logic rst_n;
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // ************************************
   // pin synchronisers
   // ************************************
   logic [2:0] clk_sync;
   logic [2:0] trg_sync;
   logic clk_stable;
   logic trg_stable;
   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         clk_sync <= 3'h0;
         trg_sync <= 3'h0;
         clk_stable <= 1'b0;
         trg_stable <= 1'b0;
      end else begin
         clk_sync <= {clk_sync[1:0], i_ext_clk};
         trg_sync <= {trg_sync[1:0], i_ext_trig};
         if (clk_sync[1] == clk_sync[2]) begin
            clk_stable <= clk_sync[2];
         end
         if (trg_sync[1] == trg_sync[2]) begin
            trg_stable <= trg_sync[2];
         end
      end
   end
   logic clk_rise;
   logic trg_rise;
   logic trg_fall;
   assign clk_rise = (clk_sync[1] == clk_sync[2]) && clk_sync[2] && !clk_stable;
   assign trg_rise = (trg_sync[1] == trg_sync[2]) && trg_sync[2] && !trg_stable;
   assign trg_fall = (trg_sync[1] == trg_sync[2]) && !trg_sync[2] && trg_stable;

   // ************************************
   // registers
   // ************************************
   logic [31:0] ctrl;
   logic [31:0] trig;
   logic [15:0] about_cnt;
   logic [2:0] div_code;
   logic [AW-1:0] mem_idx;
   logic xfer;
   logic wr_en;
   logic start_cmd;
   logic stop_cmd;
   adcatc_state_t state;
   adcatc_pkg::adcatc_mode_t mode;

   assign xfer = psel && penable && pready;
   assign wr_en = xfer && pwrite;
   assign start_cmd = wr_en && (paddr == adcatc_pkg::ADDR_CMD) && pwdata[adcatc_pkg::CMD_START];
   assign stop_cmd = wr_en && (paddr == adcatc_pkg::ADDR_CMD) && pwdata[adcatc_pkg::CMD_STOP];
   assign mode = adcatc_pkg::adcatc_mode_t'(ctrl[adcatc_pkg::CTRL_MODE +: 2]);

   // largest supported power of two not above the request, clamped
   function automatic logic [2:0] div_to_code(input logic [15:0] req);
      logic [2:0] code;
      code = 3'h0;
      if (req >= adcatc_pkg::DIV_MAX) begin
         code = 3'h7;
      end else begin
         for (int i = 0; i < 8; i++) begin
            if (req >= (adcatc_pkg::DIV_MIN << i)) begin
               code = 3'(i);
            end
         end
      end
      return code;
   endfunction

   // settings are frozen while a capture runs
   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= adcatc_pkg::CTRL_RESET;
         trig <= adcatc_pkg::TRIG_RESET;
         about_cnt <= adcatc_pkg::ABOUT_RESET;
         div_code <= adcatc_pkg::DIV_CODE_RESET;
         mem_idx <= '0;
      end else if (wr_en) begin
         case (paddr)
            adcatc_pkg::ADDR_CTRL: begin
               if (state == ST_IDLE) begin
                  ctrl <= pwdata & 32'h0003_3771;
               end
            end
            adcatc_pkg::ADDR_DIV: begin
               if (state == ST_IDLE) begin
                  div_code <= div_to_code(pwdata[15:0]);
               end
            end
            adcatc_pkg::ADDR_TRIG: begin
               if (state == ST_IDLE) begin
                  trig <= pwdata & 32'h0007_ffff;
               end
            end
            adcatc_pkg::ADDR_ABOUT: begin
               if (state == ST_IDLE) begin
                  about_cnt <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
               end
            end
            adcatc_pkg::ADDR_MEM_IDX: begin
               mem_idx <= pwdata[AW-1:0];
            end
            default: begin
            end
         endcase
      end
   end

   // ************************************
   // trigger detection
   // ************************************
   logic ext_sel;
   logic signed [SMP_W-1:0] level;
   logic signed [SMP_W-1:0] smp;
   logic above;
   logic below;
   logic prev_ok;
   logic prev_above;
   logic prev_below;
   logic ana_hit;
   logic dig_hit;
   logic ext_hit;
   logic trig_armed;

   assign level = SMP_W'(signed'(trig[adcatc_pkg::TRIG_LEVEL +: 16]));
   assign smp = signed'(i_smp_data);
   assign above = smp > level;
   assign below = smp < level;
   // pre and about capture always use the external trigger
   assign ext_sel = ctrl[adcatc_pkg::CTRL_EXT_TRIG] || (mode != adcatc_pkg::MODE_POST);

   always_comb begin
      ana_hit = 1'b0;
      if (i_smp_valid) begin
         case ({trig[adcatc_pkg::TRIG_LEVEL_SENS], trig[adcatc_pkg::TRIG_NEG]})
            2'b00: ana_hit = prev_ok && prev_below && above;
            2'b01: ana_hit = prev_ok && prev_above && below;
            2'b10: ana_hit = above;
            2'b11: ana_hit = below;
            default: ana_hit = 1'b0;
         endcase
      end
   end
   assign dig_hit = trig[adcatc_pkg::TRIG_NEG] ? trg_fall : trg_rise;
   assign ext_hit = trig_armed && (trig[adcatc_pkg::TRIG_ANALOG] ? ana_hit : dig_hit);

   // crossing history restarts with each armed search
   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         prev_ok <= 1'b0;
         prev_above <= 1'b0;
         prev_below <= 1'b0;
      end else if (!trig_armed) begin
         prev_ok <= 1'b0;
      end else if (i_smp_valid) begin
         prev_ok <= 1'b1;
         prev_above <= above;
         prev_below <= below;
      end
   end

   // ************************************
   // capture sequencer
   // ************************************
   logic [DLY_W-1:0] dly;
   logic [15:0] post_left;
   logic [AW-1:0] wr_ptr;
   logic wrapped;
   logic circular;
   logic store;

   assign trig_armed = (state == ST_WAIT_TRIG && ext_sel && mode == adcatc_pkg::MODE_POST)
                       || state == ST_PRE_RUN;
   assign circular = (mode != adcatc_pkg::MODE_POST);
   assign store = i_smp_valid && (state == ST_POST_RUN || state == ST_PRE_RUN || state == ST_POST_CNT);

   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         dly <= '0;
         post_left <= 16'h0000;
      end else begin
         case (state)
            ST_IDLE: begin
               if (start_cmd) begin
                  state <= ST_WAIT_TRIG;
                  dly <= DLY_W'(adcatc_pkg::TRIG_DELAY_CYC);
               end
            end
            ST_WAIT_TRIG: begin
               if (stop_cmd) begin
                  state <= ST_IDLE;
               end else if (mode == adcatc_pkg::MODE_POST && ext_sel) begin
                  if (ext_hit) begin
                     state <= ST_POST_RUN;
                  end
               end else if (dly > DLY_W'(1)) begin
                  dly <= dly - DLY_W'(1);
               end else begin
                  state <= (mode == adcatc_pkg::MODE_POST) ? ST_POST_RUN : ST_PRE_RUN;
               end
            end
            ST_POST_RUN: begin
               if (stop_cmd) begin
                  state <= ST_IDLE;
               end
            end
            ST_PRE_RUN: begin
               if (stop_cmd) begin
                  state <= ST_IDLE;
               end else if (ext_hit) begin
                  if (mode == adcatc_pkg::MODE_PRE) begin
                     state <= ST_IDLE;
                  end else begin
                     state <= ST_POST_CNT;
                     post_left <= about_cnt;
                  end
               end
            end
            ST_POST_CNT: begin
               if (stop_cmd) begin
                  state <= ST_IDLE;
               end else if (i_smp_valid) begin
                  post_left <= post_left - 16'h0001;
                  if (post_left == 16'h0001) begin
                     state <= ST_IDLE;
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // ************************************
   // sample memory
   // ************************************
   logic [SMP_W-1:0] mem [DEPTH];
   always_ff @(posedge i_clk_sys) begin
      if (store) begin
         mem[wr_ptr] <= i_smp_data;
      end
   end

   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         wrapped <= 1'b0;
      end else if (start_cmd && state == ST_IDLE) begin
         wr_ptr <= '0;
         wrapped <= 1'b0;
      end else if (store) begin
         wr_ptr <= wr_ptr + AW'(1);
         if (wr_ptr == AW'(DEPTH - 1)) begin
            wrapped <= 1'b1;
         end
      end
   end

   // in pre and about capture the read index is rotated so the oldest sample is index 0
   logic [AW-1:0] rd_addr;
   assign rd_addr = (circular && wrapped) ? AW'(wr_ptr + mem_idx) : mem_idx;

   // ************************************
   // apb slave
   // ************************************
   logic mapped;
   assign mapped = (paddr[1:0] == 2'b00) && (paddr <= adcatc_pkg::ADDR_CMD);

   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !mapped;
         prdata <= 32'h0000_0000;
         if (psel && penable && !pready && !pwrite) begin
            case (paddr)
               adcatc_pkg::ADDR_CTRL: prdata <= ctrl;
               adcatc_pkg::ADDR_DIV: prdata <= 32'(adcatc_pkg::DIV_MIN) << div_code;
               adcatc_pkg::ADDR_TRIG: prdata <= trig;
               adcatc_pkg::ADDR_ABOUT: prdata <= {16'h0000, about_cnt};
               adcatc_pkg::ADDR_STATUS: prdata <= {8'h00, 8'(wr_ptr), 5'h00, wrapped, o_done,
                                                  state != ST_IDLE, 5'h00, 3'(state)};
               adcatc_pkg::ADDR_MEM_IDX: prdata <= 32'(mem_idx);
               adcatc_pkg::ADDR_MEM_DATA: prdata <= 32'(mem[rd_addr]);
               default: prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ************************************
   // converter outputs
   // ************************************
   logic running;
   assign running = (state != ST_IDLE);

   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         o_chan <= 1'b0;
         o_gain <= 3'h0;
         o_conv_run <= 1'b0;
         o_div_code <= adcatc_pkg::DIV_CODE_RESET;
         o_conv_strobe <= 1'b0;
         o_busy <= 1'b0;
         o_done <= 1'b0;
      end else begin
         o_chan <= ctrl[adcatc_pkg::CTRL_CHAN];
         o_gain <= ctrl[adcatc_pkg::CTRL_CHAN] ? ctrl[adcatc_pkg::CTRL_GAIN1 +: 3]
                                              : ctrl[adcatc_pkg::CTRL_GAIN0 +: 3];
         o_conv_run <= running && !ctrl[adcatc_pkg::CTRL_EXT_CLK];
         o_div_code <= div_code;
         o_conv_strobe <= running && ctrl[adcatc_pkg::CTRL_EXT_CLK] && clk_rise;
         o_busy <= running;
         if (running && !(state == ST_IDLE)) begin
            o_done <= 1'b0;
         end
         if (start_cmd && state == ST_IDLE) begin
            o_done <= 1'b0;
         end else if (running && (stop_cmd || (state == ST_PRE_RUN && ext_hit && mode == adcatc_pkg::MODE_PRE)
                                  || (state == ST_POST_CNT && i_smp_valid && post_left == 16'h0001))) begin
            o_done <= 1'b1;
         end
      end
   end
endmodule

// [verification/adcatc_properties.sv]
// port assertions for the acquisition control block
`timescale 1ns/10ps
module adcatc_checker (
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire logic o_conv_run,
   input wire logic [2:0] o_div_code,
   input wire logic o_conv_strobe,
   input wire logic o_busy,
   input wire logic o_done
);
   logic [2:0] cmd_cnt;
   logic [2:0] div_cnt;
   logic wr_ok;
   assign wr_ok = psel && penable && pready && pwrite;
   // ************************************
   // recent write windows
   // ************************************
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cmd_cnt <= 3'h0;
      end else if (wr_ok && paddr == adcatc_pkg::ADDR_CMD) begin
         cmd_cnt <= 3'h4;
      end else if (cmd_cnt != 3'h0) begin
         cmd_cnt <= cmd_cnt - 3'h1;
      end
   end
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         div_cnt <= 3'h0;
      end else if (wr_ok && paddr == adcatc_pkg::ADDR_DIV) begin
         div_cnt <= 3'h4;
      end else if (div_cnt != 3'h0) begin
         div_cnt <= div_cnt - 3'h1;
      end
   end
   // ************************************
   // properties
   // ************************************
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_reset_n);
   sequence s_setup;
      psel && !penable ##1 psel && penable;
   endsequence
   property p_ready_wait;
      s_setup |-> !pready ##1 pready;
   endproperty
   property p_ready_pulse;
      pready |=> !pready;
   endproperty
   property p_rdata_idle;
      !pready |-> prdata == 32'h0;
   endproperty
   property p_err_ready;
      pslverr |-> pready;
   endproperty
   property p_run_busy;
      o_conv_run |-> o_busy;
   endproperty
   property p_strobe_ext;
      o_conv_strobe |-> o_busy && !o_conv_run;
   endproperty
   property p_strobe_one;
      o_conv_strobe |=> !o_conv_strobe;
   endproperty
   property p_busy_cause;
      $rose(o_busy) |-> cmd_cnt != 3'h0;
   endproperty
   property p_done_hold;
      $fell(o_done) |-> cmd_cnt != 3'h0;
   endproperty
   property p_div_cause;
      !$stable(o_div_code) |-> div_cnt != 3'h0;
   endproperty
   a_ready_wait: assert property (p_ready_wait) else $error("pready late or early");
   a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
   a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not zero");
   a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
   a_run_busy: assert property (p_run_busy) else $error("pacer runs while idle");
   a_strobe_ext: assert property (p_strobe_ext) else $error("stray conversion strobe");
   a_strobe_one: assert property (p_strobe_one) else $error("strobe longer than one cycle");
   a_busy_cause: assert property (p_busy_cause) else $error("capture began unasked");
   a_done_hold: assert property (p_done_hold) else $error("done dropped unasked");
   a_div_cause: assert property (p_div_cause) else $error("divider changed unasked");
endmodule

// [verification/adcatc_src.sv]
// external clock, trigger and sample source
`timescale 1ns/10ps
module adcatc_src #(
   parameter int W = 16
) (
   input wire logic i_clk_sys,
   output logic o_ext_clk,
   output logic o_ext_trig,
   output logic o_smp_valid,
   output logic [W-1:0] o_smp_data
);
   initial begin
      o_ext_clk = 1'b0;
      o_ext_trig = 1'b0;
      o_smp_valid = 1'b0;
   end
   task automatic clk_edges(input int n);
      repeat (n) begin
         @(posedge i_clk_sys);
         o_ext_clk <= 1'b1;
         repeat (3) @(posedge i_clk_sys);
         o_ext_clk <= 1'b0;
         repeat (3) @(posedge i_clk_sys);
      end
   endtask
   task automatic trig_to(input logic v);
      @(posedge i_clk_sys);
      o_ext_trig <= v;
      repeat (8) @(posedge i_clk_sys);
   endtask
   task automatic sample(input logic [W-1:0] v);
      @(posedge i_clk_sys);
      o_smp_valid <= 1'b1;
      o_smp_data <= v;
      @(posedge i_clk_sys);
      o_smp_valid <= 1'b0;
      // stale data must not look valid
      o_smp_data <= ~v;
      repeat (4) @(posedge i_clk_sys);
   endtask
endmodule

// [verification/test_adc_acquisition_trigger_control.sv]
// self-checking bench for the acquisition control block
`timescale 1ns/10ps
module test_adc_acquisition_trigger_control;
   logic i_clk_sys, i_reset_n, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic ext_clk, ext_trig, smp_valid, o_chan, o_conv_run, o_conv_strobe, o_busy, o_done;
   logic [15:0] smp_data;
   logic [2:0] o_gain, o_div_code;
   int errors, n_tests, n_strb;
   adcatc_top #(.DEPTH(16)) u_adcatc_top (.i_clk_sys, .i_reset_n, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pready, .prdata, .pslverr, .i_ext_clk(ext_clk), .i_ext_trig(ext_trig),
      .i_smp_valid(smp_valid), .i_smp_data(smp_data), .o_chan, .o_gain, .o_conv_run, .o_div_code,
      .o_conv_strobe, .o_busy, .o_done);
   adcatc_src u_adcatc_src (.i_clk_sys, .o_ext_clk(ext_clk), .o_ext_trig(ext_trig),
      .o_smp_valid(smp_valid), .o_smp_data(smp_data));
   initial begin
      i_clk_sys = 1'b0;
      forever #10 i_clk_sys = ~i_clk_sys;
   end
   always @(posedge i_clk_sys) if (o_conv_strobe === 1'b1) n_strb++;
   // ************************************
   // shared tasks
   // ************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge i_clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_clk_sys);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge i_clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 20) errors++;
   endtask
   task automatic start(input logic [31:0] ctrl);
      apb(1, adcatc_pkg::ADDR_CTRL, ctrl);
      apb(1, adcatc_pkg::ADDR_CMD, 32'h1);
      repeat (10) @(posedge i_clk_sys);
   endtask
   task automatic give_verdict;
      $display("comparisons %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // ************************************
   // scenarios
   // ************************************
   task automatic t_reset;
      chk({29'h0, o_div_code}, 32'h0);
      chk({31'h0, o_conv_run}, 32'h0);
      apb(0, adcatc_pkg::ADDR_DIV, 32'h0);
      chk(rd, 32'h20);
      apb(0, adcatc_pkg::ADDR_CTRL, 32'h0);
      chk(rd, 32'h0);
      apb(0, 8'h20, 32'h0);
      chk({err, rd[30:0]}, 32'h8000_0000);
   endtask
   task automatic t_div;
      logic [15:0] req[6] = '{16'h3f, 16'h40, 16'h1000, 16'h1388, 16'ha, 16'hbb8};
      logic [2:0] cod[6] = '{3'h0, 3'h1, 3'h7, 3'h7, 3'h0, 3'h6};
      for (int i = 0; i < 6; i++) begin
         apb(1, adcatc_pkg::ADDR_DIV, {16'h0, req[i]});
         apb(0, adcatc_pkg::ADDR_DIV, 32'h0);
         chk(rd, 32'h20 << cod[i]);
         chk({29'h0, o_div_code}, {29'h0, cod[i]});
      end
   endtask
   task automatic t_gain;
      for (int g = 0; g < 8; g++) begin
         apb(1, adcatc_pkg::ADDR_CTRL, (g << 4) | ((7 - g) << 8));
         repeat (2) @(posedge i_clk_sys);
         chk({29'h0, o_gain}, g);
         apb(1, adcatc_pkg::ADDR_CTRL, (g << 4) | ((7 - g) << 8) | 1);
         repeat (2) @(posedge i_clk_sys);
         chk({29'h0, o_gain}, 7 - g);
      end
   endtask
   task automatic t_post;
      apb(1, adcatc_pkg::ADDR_DIV, 32'h80);
      start(32'h0000_0521);
      chk({o_chan, o_gain, o_conv_run, o_busy}, 6'h37);
      chk({29'h0, o_div_code}, 32'h2);
      repeat (40) @(posedge i_clk_sys);
      chk({30'h0, o_busy, o_done}, 32'h2);
      apb(1, adcatc_pkg::ADDR_CMD, 32'h2);
      repeat (4) @(posedge i_clk_sys);
      chk({30'h0, o_busy, o_done}, 32'h1);
   endtask
   task automatic t_ext;
      apb(1, adcatc_pkg::ADDR_CTRL, 32'h1_0000);
      n_strb = 0;
      u_adcatc_src.clk_edges(2);
      start(32'h1_0000);
      chk(n_strb, 32'h0);
      u_adcatc_src.clk_edges(5);
      chk({o_conv_run, n_strb[30:0]}, 32'h5);
      apb(1, adcatc_pkg::ADDR_CMD, 32'h2);
   endtask
   task automatic t_post_ext;
      apb(1, adcatc_pkg::ADDR_TRIG, 32'h0);
      start(32'h2_0000);
      u_adcatc_src.sample(16'h55);
      apb(0, adcatc_pkg::ADDR_STATUS, 32'h0);
      chk({24'h0, rd[23:16]}, 32'h0);
      u_adcatc_src.trig_to(1);
      u_adcatc_src.sample(16'h56);
      apb(0, adcatc_pkg::ADDR_STATUS, 32'h0);
      chk({24'h0, rd[23:16]}, 32'h1);
      apb(1, adcatc_pkg::ADDR_MEM_IDX, 32'h0);
      apb(0, adcatc_pkg::ADDR_MEM_DATA, 32'h0);
      chk(rd, 32'h56);
      apb(1, adcatc_pkg::ADDR_CMD, 32'h2);
      u_adcatc_src.trig_to(0);
   endtask
   task automatic t_dig;
      for (int p = 0; p < 2; p++) begin
         apb(1, adcatc_pkg::ADDR_TRIG, p << 17);
         u_adcatc_src.trig_to(p);
         u_adcatc_src.trig_to(!p);
         start(32'h1000);
         chk({31'h0, o_done}, 32'h0);
         u_adcatc_src.trig_to(p);
         chk({31'h0, o_done}, 32'h0);
         u_adcatc_src.trig_to(!p);
         chk({30'h0, o_busy, o_done}, 32'h1);
      end
   endtask
   task automatic t_ana;
      logic [15:0] v;
      for (int c = 0; c < 4; c++) begin
         apb(1, adcatc_pkg::ADDR_TRIG, 32'h1_0000 | (c << 17));
         start(32'h1000);
         v = c[0] ? 16'hfff6 : 16'ha;
         for (int k = 1; k < 4; k++) begin
            u_adcatc_src.sample(k[0] ? v : -v);
            chk({31'h0, o_done}, (k >= (c[1] ? 1 : 3)));
         end
      end
   endtask
   task automatic t_about;
      u_adcatc_src.trig_to(0);
      apb(1, adcatc_pkg::ADDR_TRIG, 32'h0);
      apb(1, adcatc_pkg::ADDR_ABOUT, 32'h3);
      start(32'h2000);
      for (int k = 0; k < 20; k++) u_adcatc_src.sample(16'h100 + k);
      u_adcatc_src.trig_to(1);
      u_adcatc_src.sample(16'h200);
      u_adcatc_src.sample(16'h201);
      chk({31'h0, o_done}, 32'h0);
      u_adcatc_src.sample(16'h202);
      chk({30'h0, o_busy, o_done}, 32'h1);
      apb(1, adcatc_pkg::ADDR_MEM_IDX, 32'hf);
      apb(0, adcatc_pkg::ADDR_MEM_DATA, 32'h0);
      chk(rd, 32'h202);
      apb(1, adcatc_pkg::ADDR_MEM_IDX, 32'h0);
      apb(0, adcatc_pkg::ADDR_MEM_DATA, 32'h0);
      chk(rd, 32'h107);
   endtask
   initial begin
      i_reset_n = 1'b0;
      {psel, penable} = '0;
      repeat (8) @(posedge i_clk_sys);
      i_reset_n <= 1'b1;
      repeat (3) @(posedge i_clk_sys);
      t_reset();
      t_div();
      t_gain();
      t_post();
      t_ext();
      t_post_ext();
      t_dig();
      t_ana();
      t_about();
      give_verdict();
   end
   initial begin
      #1_000_000;
      errors++;
      give_verdict();
   end
endmodule
bind adcatc_top adcatc_checker u_adcatc_checker (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr),
   .o_conv_run(o_conv_run), .o_div_code(o_div_code), .o_conv_strobe(o_conv_strobe), .o_busy(o_busy),
   .o_done(o_done));
